// ==== verilog/sap_pkg.sv ====
/*
 * Constants, object dictionary map and types of the safe absolute position block.
 * Assumes a 200 MHz clock and one axis object group on the safety fieldbus.
 */
package sap_pkg;
   // Object dictionary group of this axis
   localparam logic [15:0] OD_INDEX = 16'h3150;
   localparam logic [7:0] SUB_ENC_SRC = 8'h01;
   localparam logic [7:0] SUB_INTERVAL = 8'h03;
   localparam logic [7:0] SUB_ENABLE = 8'h04;
   localparam logic [7:0] SUB_HOME_SRC = 8'h05;
   localparam logic [7:0] SUB_RANGE = 8'h06;
   localparam logic [7:0] SUB_HOME_POS = 8'h07;
   localparam logic [7:0] SUB_VALID = 8'h08;
   // Encoder source: 0 means no encoder
   localparam logic [7:0] ENC_SRC_NONE = 8'h00;
   localparam logic [7:0] ENC_SRC_MAX = 8'h03;
   localparam logic [7:0] ENC_SRC_RST = 8'h00;
   // Homing input selector codes
   localparam logic [7:0] HSRC_NONE = 8'h00;
   localparam logic [7:0] HSRC_IN1 = 8'h01;
   localparam logic [7:0] HSRC_IN2 = 8'h02;
   localparam logic [7:0] HSRC_IN3 = 8'h03;
   localparam logic [7:0] HSRC_IN4 = 8'h04;
   localparam logic [7:0] HSRC_DUAL12 = 8'h05;
   localparam logic [7:0] HSRC_DUAL34 = 8'h06;
   localparam logic [7:0] HSRC_RST = 8'h00;
   // Enable and range settings
   localparam logic ABS_DISABLED = 1'b0;
   localparam logic RANGE_UNSIGNED = 1'b0;
   localparam logic [31:0] HOME_POS_RST = 32'h0000_0000;
   // Acceleration interval in milliseconds
   localparam logic [7:0] INTERVAL_MIN = 8'h01;
   localparam logic [7:0] INTERVAL_MAX = 8'h64;
   localparam logic [7:0] INTERVAL_RST = 8'h01;
   localparam int MS_PERIOD_NS = 1_000_000;
   localparam int CLK_PERIOD_NS = 5;
   localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
   // Encoder word layout and safe input count defaults
   localparam int MT_BITS = 12;
   localparam int ST_BITS = 16;
   localparam int SAFE_INPUTS = 4;
   typedef enum logic [1:0] {
      SAP_IDLE,
      SAP_CHECK,
      SAP_VALID,
      SAP_INVALID
   } sap_state_t;
endpackage : sap_pkg

// ==== verilog/sap_sync.sv ====
/*
 * Two flip-flop synchroniser, one per bit.
 * Assumes the inputs are asynchronous pins.
 */
module sap_sync
   import sap_pkg::*;
#(
   parameter int W = SAFE_INPUTS
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;

   for (genvar i = 0; i < W; i++)
   begin : g_bit
      always_ff @(posedge clk)
      begin
         if (!rstn)
         begin
            meta_r[i] <= 1'b0;
            sync_r[i] <= 1'b0;
         end
         else
         begin
            meta_r[i] <= async_in[i];
            sync_r[i] <= meta_r[i];
         end
      end
   end

   assign sync_out = sync_r;
endmodule : sap_sync

// ==== verilog/sap_accel.sv ====
/*
 * Acceleration from position, sampled once per configured interval.
 * Assumes pos is the raw encoder position on the same clock, so homing adds no step.
 */
module sap_accel
   import sap_pkg::*;
#(
   parameter int AW = MT_BITS + ST_BITS,
   parameter int MS_CYC = MS_CYCLES
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic run,
   input wire logic [7:0] interval,
   input wire logic [AW-1:0] pos,
   output logic [31:0] accel,
   output logic accel_valid
);
   localparam int CW = $clog2(MS_CYC + 1);
   logic [CW-1:0] cyc_r, cyc_nxt;
   logic [7:0] ms_r, ms_nxt;
   logic [AW-1:0] pos_prev_r, pos_prev_nxt;
   logic [AW-1:0] vel_r, vel_nxt;
   logic [1:0] prime_r, prime_nxt;
   logic [31:0] acc_r, acc_nxt;
   logic acc_v_r, acc_v_nxt;
   logic [AW-1:0] acc_w;

   always_comb
   begin
      cyc_nxt = cyc_r;
      ms_nxt = ms_r;
      pos_prev_nxt = pos_prev_r;
      vel_nxt = vel_r;
      prime_nxt = prime_r;
      acc_nxt = acc_r;
      acc_v_nxt = 1'b0;
      acc_w = pos - pos_prev_r - vel_r;
      if (!run)
      begin
         cyc_nxt = '0;
         ms_nxt = 8'h00;
         prime_nxt = 2'h0;
      end
      else if (cyc_r != CW'(MS_CYC - 1))
         cyc_nxt = cyc_r + CW'(1);
      else
      begin
         cyc_nxt = '0;
         if (ms_r + 8'h01 < interval)
            ms_nxt = ms_r + 8'h01;
         else
         begin
            // Interval end: new velocity and its difference
            ms_nxt = 8'h00;
            pos_prev_nxt = pos;
            vel_nxt = pos - pos_prev_r;
            if (prime_r != 2'h2)
               prime_nxt = prime_r + 2'h1;
            if (prime_r == 2'h2)
            begin
               acc_nxt = 32'(signed'(acc_w));
               acc_v_nxt = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         cyc_r <= '0;
         ms_r <= 8'h00;
         pos_prev_r <= '0;
         vel_r <= '0;
         prime_r <= 2'h0;
         acc_r <= 32'h0000_0000;
         acc_v_r <= 1'b0;
      end
      else
      begin
         cyc_r <= cyc_nxt;
         ms_r <= ms_nxt;
         pos_prev_r <= pos_prev_nxt;
         vel_r <= vel_nxt;
         prime_r <= prime_nxt;
         acc_r <= acc_nxt;
         acc_v_r <= acc_v_nxt;
      end
   end

   a_accel_needs_encoder: assert property (@(posedge clk) disable iff (!rstn)
      !run |=> !acc_v_r) else $error("acceleration produced without encoder");

   assign accel = acc_r;
   assign accel_valid = acc_v_r;
endmodule : sap_accel

// ==== verilog/sap_abs_pos.sv ====
/*
 * Safe absolute position check: stored position compare, safe homing,
 * signed or unsigned multi-turn range with rollover, acceleration.
 * Assumes encoder words and the stored position come from logic on clk;
 * safe inputs are asynchronous pins. Settings are reached as object
 * dictionary entries, one request per od_req pulse.
 */
module sap_abs_pos
   import sap_pkg::*;
#(
   parameter int MT_W = MT_BITS,
   parameter int ST_W = ST_BITS,
   parameter int MS_CYC = MS_CYCLES
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic od_req,
   input wire logic od_we,
   input wire logic [15:0] od_index,
   input wire logic [7:0] od_subindex,
   input wire logic [31:0] od_wdata,
   output logic [31:0] od_rdata,
   output logic od_ack,
   output logic od_err,
   input wire logic enc_sample,
   input wire logic [MT_W-1:0] enc_mt,
   input wire logic [ST_W-1:0] enc_st,
   input wire logic [SAFE_INPUTS-1:0] safe_in,
   input wire logic [MT_W+ST_W-1:0] nvm_pos,
   output logic nvm_wr,
   output logic [MT_W+ST_W-1:0] nvm_wdata,
   output logic [31:0] abs_pos,
   output logic abs_pos_valid,
   output logic [31:0] accel,
   output logic accel_valid
);
   localparam int AW = MT_W + ST_W;

   sap_state_t state_r, state_nxt;
   logic [7:0] enc_src_r, enc_src_nxt;
   logic [7:0] interval_r, interval_nxt;
   logic enable_r, enable_nxt;
   logic range_r, range_nxt;
   logic [7:0] home_sel_r, home_sel_nxt;
   logic [31:0] home_pos_r, home_pos_nxt;
   logic [AW-1:0] offset_r, offset_nxt;
   logic [AW-1:0] raw_r, raw_nxt;
   logic [AW-1:0] cur_r, cur_nxt;
   logic home_prev_r, home_prev_nxt;
   logic [31:0] od_rdata_r, od_rdata_nxt;
   logic od_ack_r, od_ack_nxt;
   logic od_err_r, od_err_nxt;
   logic nvm_wr_r, nvm_wr_nxt;
   logic [AW-1:0] nvm_wdata_r, nvm_wdata_nxt;
   logic [31:0] abs_pos_r, abs_pos_nxt;
   logic valid_r, valid_nxt;

   logic [SAFE_INPUTS-1:0] sin;
   logic cfg_ok;
   logic signed_eff;
   logic [AW-1:0] raw_now;
   logic [AW-1:0] pos_sum;
   logic [AW-1:0] home_val;
   logic home_lvl;
   logic home_evt;
   logic od_hit;

   sap_sync #(.W(SAFE_INPUTS)) u_sync (
      .clk(clk),
      .rstn(rstn),
      .async_in(safe_in),
      .sync_out(sin)
   );

   sap_accel #(.AW(AW), .MS_CYC(MS_CYC)) u_accel (
      .clk(clk),
      .rstn(rstn),
      .run(enc_src_r != ENC_SRC_NONE),
      .interval(interval_r),
      .pos(cur_r),
      .accel(accel),
      .accel_valid(accel_valid)
   );

   // Sign- or zero-extend a wrapped position word to 32 bits
   function automatic logic [31:0] present(input logic [AW-1:0] v, input logic sgn);
      present = sgn ? 32'(signed'(v)) : 32'(v);
   endfunction : present

   always_comb
   begin
      cfg_ok = enable_r && (enc_src_r != ENC_SRC_NONE);
      signed_eff = cfg_ok && range_r;
      raw_now = enc_sample ? {enc_mt, enc_st} : raw_r;
      pos_sum = raw_now + offset_r;
      home_val = home_pos_r[AW-1:0];
      case (home_sel_r)
         HSRC_IN1: home_lvl = sin[0];
         HSRC_IN2: home_lvl = sin[1];
         HSRC_IN3: home_lvl = sin[2];
         HSRC_IN4: home_lvl = sin[3];
         HSRC_DUAL12: home_lvl = sin[0] && sin[1];
         HSRC_DUAL34: home_lvl = sin[2] && sin[3];
         default: home_lvl = 1'b0;
      endcase
      home_evt = cfg_ok && (state_r != SAP_IDLE) && home_lvl && !home_prev_r;
   end

   // Object dictionary access
   always_comb
   begin
      enc_src_nxt = enc_src_r;
      interval_nxt = interval_r;
      enable_nxt = enable_r;
      range_nxt = range_r;
      home_sel_nxt = home_sel_r;
      home_pos_nxt = home_pos_r;
      od_ack_nxt = od_req;
      od_err_nxt = 1'b0;
      od_rdata_nxt = 32'h0000_0000;
      od_hit = od_req && (od_index == OD_INDEX);
      if (od_req && !od_hit)
         od_err_nxt = 1'b1;
      else if (od_hit)
      begin
         case (od_subindex)
            SUB_ENC_SRC:
            begin
               od_rdata_nxt = 32'(enc_src_r);
               if (od_we && od_wdata <= 32'(ENC_SRC_MAX))
                  enc_src_nxt = od_wdata[7:0];
               else if (od_we)
                  od_err_nxt = 1'b1;
            end
            SUB_INTERVAL:
            begin
               od_rdata_nxt = 32'(interval_r);
               if (od_we && od_wdata >= 32'(INTERVAL_MIN) && od_wdata <= 32'(INTERVAL_MAX))
                  interval_nxt = od_wdata[7:0];
               else if (od_we)
                  od_err_nxt = 1'b1;
            end
            SUB_ENABLE:
            begin
               od_rdata_nxt = 32'(enable_r);
               if (od_we && od_wdata[31:1] == 31'h0000_0000)
                  enable_nxt = od_wdata[0];
               else if (od_we)
                  od_err_nxt = 1'b1;
            end
            SUB_HOME_SRC:
            begin
               od_rdata_nxt = 32'(home_sel_r);
               if (od_we && cfg_ok && od_wdata <= 32'(HSRC_DUAL34))
                  home_sel_nxt = od_wdata[7:0];
               else if (od_we)
                  od_err_nxt = 1'b1;
            end
            SUB_RANGE:
            begin
               od_rdata_nxt = 32'(range_r);
               if (od_we && od_wdata[31:1] == 31'h0000_0000)
                  range_nxt = od_wdata[0];
               else if (od_we)
                  od_err_nxt = 1'b1;
            end
            SUB_HOME_POS:
            begin
               od_rdata_nxt = home_pos_r;
               if (od_we)
                  home_pos_nxt = od_wdata;
            end
            SUB_VALID:
            begin
               od_rdata_nxt = 32'(valid_r);
               od_err_nxt = od_we;
            end
            default: od_err_nxt = 1'b1;
         endcase
      end
   end

   // Validity, homing and presented position
   always_comb
   begin
      state_nxt = state_r;
      offset_nxt = offset_r;
      raw_nxt = raw_now;
      cur_nxt = enc_sample ? {enc_mt, enc_st} : cur_r;
      home_prev_nxt = home_lvl;
      nvm_wr_nxt = 1'b0;
      nvm_wdata_nxt = nvm_wdata_r;
      abs_pos_nxt = abs_pos_r;
      if (enc_sample)
         abs_pos_nxt = present(pos_sum, signed_eff);
      case (state_r)
         SAP_IDLE:
            if (cfg_ok)
               state_nxt = SAP_CHECK;
         SAP_CHECK:
            if (!cfg_ok)
               state_nxt = SAP_IDLE;
            else if (enc_sample && pos_sum == nvm_pos)
               state_nxt = SAP_VALID;
            else if (enc_sample)
               state_nxt = SAP_INVALID;
         SAP_VALID:
            if (!cfg_ok)
               state_nxt = SAP_IDLE;
            else if (enc_sample)
            begin
               nvm_wr_nxt = 1'b1;
               nvm_wdata_nxt = pos_sum;
            end
         SAP_INVALID:
            if (!cfg_ok)
               state_nxt = SAP_IDLE;
         default: state_nxt = SAP_IDLE;
      endcase
      // Homing overrides a mismatch in the same cycle
      if (home_evt)
      begin
         offset_nxt = home_val - raw_now;
         state_nxt = SAP_VALID;
         nvm_wr_nxt = 1'b1;
         nvm_wdata_nxt = home_val;
         abs_pos_nxt = present(home_val, signed_eff);
      end
      valid_nxt = (state_nxt == SAP_VALID);
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         state_r <= SAP_IDLE;
         enc_src_r <= ENC_SRC_RST;
         interval_r <= INTERVAL_RST;
         enable_r <= ABS_DISABLED;
         range_r <= RANGE_UNSIGNED;
         home_sel_r <= HSRC_RST;
         home_pos_r <= HOME_POS_RST;
         offset_r <= '0;
         raw_r <= '0;
         cur_r <= '0;
         home_prev_r <= 1'b0;
         od_rdata_r <= 32'h0000_0000;
         od_ack_r <= 1'b0;
         od_err_r <= 1'b0;
         nvm_wr_r <= 1'b0;
         nvm_wdata_r <= '0;
         abs_pos_r <= 32'h0000_0000;
         valid_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         enc_src_r <= enc_src_nxt;
         interval_r <= interval_nxt;
         enable_r <= enable_nxt;
         range_r <= range_nxt;
         home_sel_r <= home_sel_nxt;
         home_pos_r <= home_pos_nxt;
         offset_r <= offset_nxt;
         raw_r <= raw_nxt;
         cur_r <= cur_nxt;
         home_prev_r <= home_prev_nxt;
         od_rdata_r <= od_rdata_nxt;
         od_ack_r <= od_ack_nxt;
         od_err_r <= od_err_nxt;
         nvm_wr_r <= nvm_wr_nxt;
         nvm_wdata_r <= nvm_wdata_nxt;
         abs_pos_r <= abs_pos_nxt;
         valid_r <= valid_nxt;
      end
   end

   a_match_valid: assert property (@(posedge clk) disable iff (!rstn)
      state_r == SAP_CHECK && cfg_ok && enc_sample && pos_sum == nvm_pos |=> valid_r)
      else $error("matching position not marked valid");
   a_mismatch_invalid: assert property (@(posedge clk) disable iff (!rstn)
      state_r == SAP_CHECK && enc_sample && pos_sum != nvm_pos && !home_evt |=> !valid_r)
      else $error("mismatching position marked valid");
   a_invalid_holds: assert property (@(posedge clk) disable iff (!rstn)
      state_r == SAP_INVALID && !home_evt |=> !valid_r)
      else $error("valid returned without homing");
   a_disable_clears: assert property (@(posedge clk) disable iff (!rstn)
      !enable_r |=> !valid_r && state_r == SAP_IDLE)
      else $error("valid while support disabled");
   a_signed_range: assert property (@(posedge clk) disable iff (!rstn)
      enc_sample && !home_evt |=> abs_pos_r == present($past(pos_sum), $past(signed_eff)))
      else $error("presented position wrong");
   a_sel_encoding: assert property (@(posedge clk) disable iff (!rstn)
      home_sel_r <= HSRC_DUAL34) else $error("homing selector out of range");
   a_sel_refused: assert property (@(posedge clk) disable iff (!rstn)
      od_hit && od_we && od_subindex == SUB_HOME_SRC && !cfg_ok
      |=> od_ack_r && od_err_r && $stable(home_sel_r))
      else $error("homing selector write not refused");
   a_home_store: assert property (@(posedge clk) disable iff (!rstn)
      home_evt |=> nvm_wr_r && nvm_wdata_r == $past(home_val) && valid_r)
      else $error("homing not stored or not valid");
   a_interval_range: assert property (@(posedge clk) disable iff (!rstn)
      interval_r >= INTERVAL_MIN && interval_r <= INTERVAL_MAX)
      else $error("interval outside limits");

   assign od_rdata = od_rdata_r;
   assign od_ack = od_ack_r;
   assign od_err = od_err_r;
   assign nvm_wr = nvm_wr_r;
   assign nvm_wdata = nvm_wdata_r;
   assign abs_pos = abs_pos_r;
   assign abs_pos_valid = valid_r;
endmodule : sap_abs_pos

// ==== test/sap_enc_model.sv ====
/*
 * Behavioural safe encoder: periodic multi-turn and single-turn samples.
 * Assumes the bench sets period, step and start position (jump).
 */
module sap_enc_model
   import sap_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] period,
   input wire logic signed [7:0] step,
   output logic enc_sample,
   output logic [MT_BITS-1:0] enc_mt,
   output logic [ST_BITS-1:0] enc_st
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int AW = MT_BITS + ST_BITS;
   logic [AW-1:0] pos;
   logic [7:0] cnt;

   // Lands off the clock edge so the sampling process never races it
   task jump(input logic [AW-1:0] v);
      #1;
      pos = v;
   endtask : jump

   initial {enc_sample, enc_mt, enc_st} = '0;

   // Data lines toggle between samples so stale words never look valid
   always @(posedge clk)
   begin
      if (!rstn)
      begin
         cnt <= 8'h00;
         enc_sample <= 1'b0;
      end
      else if (cnt + 8'h01 >= period)
      begin
         cnt <= 8'h00;
         pos <= pos + AW'(step);
         {enc_mt, enc_st} <= pos + AW'(step);
         enc_sample <= 1'b1;
      end
      else
      begin
         cnt <= cnt + 8'h01;
         {enc_mt, enc_st} <= ~{enc_mt, enc_st};
         enc_sample <= 1'b0;
      end
   end
endmodule : sap_enc_model

// ==== test/tb.sv ====
/*
 * Self-checking bench of the safe absolute position block.
 * Assumes the encoder model beside it; the bench plays NVM and controller.
 */
module tb;
   import sap_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int AW = MT_BITS + ST_BITS;
   localparam logic [AW-1:0] RAW = 28'h012_3456;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic od_req = 1'b0;
   logic od_we = 1'b0;
   logic [15:0] od_index = 16'h0000;
   logic [7:0] od_subindex = 8'h00;
   logic [31:0] od_wdata = 32'h0000_0000;
   logic [3:0] safe_in = 4'h0;
   logic [AW-1:0] nvm_pos = RAW;
   logic [7:0] period = 8'h02;
   logic signed [7:0] step = 8'sd3;
   logic [15:0] idx = OD_INDEX;
   logic [31:0] od_rdata, abs_pos, accel;
   logic od_ack, od_err, enc_sample, nvm_wr, abs_pos_valid, accel_valid;
   logic [MT_BITS-1:0] enc_mt;
   logic [ST_BITS-1:0] enc_st;
   logic [AW-1:0] nvm_wdata;
   logic [7:0] subs [7] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
   logic [31:0] rst_vals [7] = '{0, 1, 0, 0, 0, 0, 0};
   int n_errors = 0;
   int cmp_count = 0;
   int n_acc = 0;
   int i;

   sap_abs_pos #(.MS_CYC(10)) i_dut (.clk(clk), .rstn(rstn), .od_req(od_req), .od_we(od_we),
      .od_index(od_index), .od_subindex(od_subindex), .od_wdata(od_wdata),
      .od_rdata(od_rdata), .od_ack(od_ack), .od_err(od_err), .enc_sample(enc_sample),
      .enc_mt(enc_mt), .enc_st(enc_st), .safe_in(safe_in), .nvm_pos(nvm_pos),
      .nvm_wr(nvm_wr), .nvm_wdata(nvm_wdata), .abs_pos(abs_pos),
      .abs_pos_valid(abs_pos_valid), .accel(accel), .accel_valid(accel_valid));

   sap_enc_model i_enc (.clk(clk), .rstn(rstn), .period(period), .step(step),
      .enc_sample(enc_sample), .enc_mt(enc_mt), .enc_st(enc_st));

   always #2.5 clk = ~clk;

   // Non-volatile store follows every write pulse
   always @(posedge clk)
   begin
      if (nvm_wr === 1'b1)
         nvm_pos <= nvm_wdata;
      if (accel_valid === 1'b1)
         n_acc <= n_acc + 1;
   end

   task test_done;
      if (n_errors == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : test_done

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task acc(input logic we, input logic [7:0] sub, input logic [31:0] d, input logic e,
            input logic [31:0] r);
      @(posedge clk);
      od_req <= 1'b1;
      od_we <= we;
      od_index <= idx;
      od_subindex <= sub;
      od_wdata <= d;
      @(posedge clk);
      od_req <= 1'b0;
      #1;
      chk(32'(od_ack), 32'h0000_0001);
      chk(32'(od_err), 32'(e));
      chk(od_rdata, r);
   endtask : acc

   // Waits for the next encoder sample, then for position and check to land
   task after_sample;
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
      end
      while (enc_sample !== 1'b1 && n < 50);
      chk(32'(enc_sample), 32'h0000_0001);
      repeat (2) @(posedge clk);
      #1;
   endtask : after_sample

   // Whole sequence needs well under a thousand cycles
   initial
   begin
      repeat (4000) @(posedge clk);
      n_errors++;
      test_done;
   end

   initial
   begin
      i_enc.jump(RAW);
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      for (i = 0; i < 7; i++)
         acc(1'b0, subs[i], 0, 1'b0, rst_vals[i]);
      idx = 16'h3250;
      acc(1'b0, SUB_ENABLE, 0, 1'b1, 0);
      idx = OD_INDEX;
      acc(1'b1, SUB_VALID, 1, 1'b1, 0);
      acc(1'b1, SUB_ENABLE, 32'h0000_0002, 1'b1, 0);
      acc(1'b1, SUB_HOME_SRC, 1, 1'b1, 0);
      acc(1'b1, SUB_INTERVAL, 0, 1'b1, 32'h0000_0001);
      acc(1'b1, SUB_INTERVAL, 32'h0000_0065, 1'b1, 32'h0000_0001);
      acc(1'b1, SUB_INTERVAL, 32'h0000_0064, 1'b0, 32'h0000_0001);
      acc(1'b0, SUB_INTERVAL, 0, 1'b0, 32'h0000_0064);
      acc(1'b1, SUB_INTERVAL, 1, 1'b0, 32'h0000_0064);
      repeat (60) @(posedge clk);
      chk(32'(n_acc), 0);
      acc(1'b1, SUB_ENC_SRC, 1, 1'b0, 0);
      i = 0;
      do
      begin
         @(posedge clk);
         #1;
         i++;
      end
      while (accel_valid !== 1'b1 && i < 200);
      chk(32'(accel_valid), 32'h0000_0001);
      chk(accel, 0);
      @(posedge clk);
      step <= 8'sd0;
      period <= 8'h07;
      nvm_pos <= RAW;
      @(posedge clk);
      i_enc.jump(RAW);
      acc(1'b1, SUB_ENABLE, 1, 1'b0, 0);
      after_sample;
      chk(32'(abs_pos_valid), 32'h0000_0001);
      chk(abs_pos, 32'h0012_3456);
      acc(1'b0, SUB_VALID, 0, 1'b0, 1);
      acc(1'b1, SUB_ENABLE, 0, 1'b0, 1);
      // Past the last store pulse, so the stored word is not overwritten
      repeat (2) @(posedge clk);
      nvm_pos <= RAW + 28'h000_0001;
      acc(1'b1, SUB_ENABLE, 1, 1'b0, 0);
      after_sample;
      chk(32'(abs_pos_valid), 0);
      acc(1'b0, SUB_VALID, 0, 1'b0, 0);
      for (i = 1; i < 8; i++)
         acc(1'b1, SUB_HOME_SRC, i, i == 7, i - 1);
      acc(1'b0, SUB_HOME_SRC, 0, 1'b0, 6);
      acc(1'b1, SUB_HOME_SRC, 1, 1'b0, 6);
      acc(1'b1, SUB_HOME_POS, 0, 1'b0, 0);
      @(posedge clk);
      safe_in <= 4'h1;
      i = 0;
      do
      begin
         @(posedge clk);
         #1;
         i++;
      end
      while (nvm_wr !== 1'b1 && i < 20);
      chk(32'(nvm_wr), 32'h0000_0001);
      chk(32'(nvm_wdata), 0);
      chk(32'(abs_pos_valid), 32'h0000_0001);
      chk(abs_pos, 0);
      @(posedge clk);
      safe_in <= 4'h0;
      i_enc.jump(RAW - 28'h000_0001);
      after_sample;
      chk(abs_pos, 32'h0FFF_FFFF);
      acc(1'b1, SUB_RANGE, 1, 1'b0, 0);
      after_sample;
      chk(abs_pos, 32'hFFFF_FFFF);
      // Dual input homing needs both inputs of the pair
      acc(1'b1, SUB_HOME_SRC, 6, 1'b0, 1);
      acc(1'b1, SUB_HOME_POS, 5, 1'b0, 0);
      @(posedge clk);
      safe_in <= 4'h4;
      after_sample;
      chk(abs_pos, 32'hFFFF_FFFF);
      @(posedge clk);
      safe_in <= 4'hC;
      i = 0;
      do
      begin
         @(posedge clk);
         #1;
         i++;
      end
      while (abs_pos !== 32'h0000_0005 && i < 20);
      chk(abs_pos, 32'h0000_0005);
      chk(32'(nvm_wdata), 32'h0000_0005);
      test_done;
   end
endmodule : tb
